/* File: verilog/rmf_pkg.sv */
package rmf_pkg;

	// ==================================================
	// register map (byte addresses, 32-bit words)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SAMPLE = 8'h04;
	localparam logic [7:0] ADDR_RESUME = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// internal register selects shared by the bus and the command port
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_SAMPLE = 2'h1;
	localparam logic [1:0] SEL_RESUME = 2'h2;
	localparam logic [1:0] SEL_STATUS = 2'h3;

	// control word fields
	localparam int CTRL_HOLD = 0;
	localparam int CTRL_DUMP = 1;
	localparam int CTRL_PREFIX_OFF = 2;
	localparam int CTRL_ADDRESSED = 3;
	localparam int CTRL_RES_LO = 4;
	localparam int RES_W = 2;
	localparam logic [15:0] SAMPLE_RESET = 16'h0000;

	// status word fields
	localparam int STAT_FULL = 0;
	localparam int STAT_PEND = 1;
	localparam int STAT_WAIT = 2;
	localparam int STAT_SEND = 3;
	localparam int STAT_GATE = 4;
	localparam int STAT_DWELL = 5;

	// ==================================================
	// message layout
	localparam logic [4:0] MSG_LEN = 5'h15;
	localparam logic [4:0] IDX_FIRST = 5'h01;
	localparam logic [4:0] IDX_SECOND = 5'h02;
	localparam logic [4:0] IDX_SPACE = 5'h03;
	localparam logic [4:0] IDX_SIGN = 5'h04;
	localparam logic [4:0] IDX_MANT_LO = 5'h05;
	localparam logic [4:0] IDX_MANT_HI = 5'h11;
	localparam logic [4:0] IDX_E = 5'h12;
	localparam logic [4:0] IDX_EXP_SIGN = 5'h13;
	localparam logic [4:0] IDX_EXP_HI = 5'h14;
	localparam int MANT_DIGITS = 12;
	localparam logic [4:0] DUMP_C_ZEROS = 5'h04;
	localparam logic [3:0] DUMP_AB_DIGITS = 4'h4;

	// ascii characters
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_POINT = 8'h2E;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_E = 8'h45;

	// function codes of a result
	localparam logic [3:0] FN_INPUT_A = 4'h0;
	localparam logic [3:0] FN_INPUT_B = 4'h1;
	localparam logic [3:0] FN_INPUT_C = 4'h2;
	localparam logic [3:0] FN_CHECK = 4'h3;
	localparam logic [3:0] FN_RATIO_CB = 4'h4;
	localparam logic [3:0] FN_RATIO_CA = 4'h5;
	localparam logic [3:0] FN_RATIO_BA = 4'h6;
	localparam logic [3:0] FN_RESOLUTION = 4'h7;
	localparam logic [3:0] FN_MANUAL = 4'h8;
	localparam logic [3:0] FN_OFFSET = 4'h9;
	localparam logic [3:0] FN_MULT = 4'hA;
	localparam logic [3:0] FN_SAMPLE = 4'hB;
	localparam logic [3:0] FN_HARMONIC = 4'hC;
	localparam logic [3:0] FN_LOCAL_OSC = 4'hD;

	// ==================================================
	// timing
	localparam int CLOCK_PERIOD_NS = 4;
	localparam int MS_IN_NS = 1000000;
	localparam int MS_CYCLES = MS_IN_NS / CLOCK_PERIOD_NS;
	localparam logic [25:0] MS_PER_S = 26'h00003E8;
	localparam logic [25:0] GATE_MS_RES0 = 26'h0000001;
	localparam logic [25:0] GATE_MS_RES1 = 26'h000000A;
	localparam logic [25:0] GATE_MS_RES2 = 26'h0000064;
	localparam logic [25:0] GATE_MS_RES3 = 26'h00003E8;

	// ==================================================
	// types
	typedef enum logic [1:0] {M_IDLE, M_GATE, M_DWELL} rmf_meas_type;
	typedef enum logic [1:0] {X_IDLE, X_WAIT, X_SEND} rmf_xfer_type;

	typedef struct packed {
		logic [3:0] func;
		logic neg;
		logic [47:0] digits;
		logic [3:0] point;
		logic expNeg;
		logic [7:0] expBcd;
	} rmf_result_type;

endpackage

/* File: verilog/rmf_char_gen.sv */
`timescale 1ns/1ps

module rmf_char_gen import rmf_pkg::*; (
	// message position, first byte is 1
	input wire logic [4:0] idx,
	// buffered value
	input wire logic [3:0] funcCode,
	input wire logic neg,
	input wire logic [47:0] digits,
	input wire logic [3:0] point,
	input wire logic expNeg,
	input wire logic [7:0] expBcd,
	input wire logic dumpMode,
	// character at idx
	output logic [7:0] ch
);

	// ==================================================
	// lookups
	function automatic logic [15:0] funcLetters(input logic [3:0] code);
		unique case (code)
			FN_INPUT_A: funcLetters = 16'h4641;
			FN_INPUT_B: funcLetters = 16'h4642;
			FN_INPUT_C: funcLetters = 16'h4643;
			FN_CHECK: funcLetters = 16'h434B;
			FN_RATIO_CB: funcLetters = 16'h4342;
			FN_RATIO_CA: funcLetters = 16'h4341;
			FN_RATIO_BA: funcLetters = 16'h4241;
			FN_RESOLUTION: funcLetters = 16'h5253;
			FN_MANUAL: funcLetters = 16'h4D4E;
			FN_OFFSET: funcLetters = 16'h4F53;
			FN_MULT: funcLetters = 16'h4D55;
			FN_SAMPLE: funcLetters = 16'h5341;
			FN_HARMONIC: funcLetters = 16'h484E;
			FN_LOCAL_OSC: funcLetters = 16'h4C4F;
			default: funcLetters = {CH_SPACE, CH_SPACE};
		endcase
	endfunction

	function automatic logic [7:0] digitChar(input logic [47:0] all, input logic [4:0] d);
		logic [3:0] nib;
		nib = 4'h0;
		for (int k = 0; k < MANT_DIGITS; k++) begin
			if (d == 5'(k)) begin
				nib = all[(MANT_DIGITS - 1 - k) * 4 +: 4];
			end
		end
		digitChar = CH_ZERO | {4'h0, nib};
	endfunction

	// ==================================================
	// character selection
	logic [4:0] pos;
	logic [4:0] dig;
	logic [15:0] letters;
	logic isInputAB;
	assign pos = idx - IDX_MANT_LO;
	assign dig = (pos < {1'b0, point}) ? pos : pos - 5'h01;
	assign letters = funcLetters(funcCode);
	assign isInputAB = (funcCode == FN_INPUT_A) || (funcCode == FN_INPUT_B);

	always_comb begin
		ch = CH_SPACE;
		if (idx == IDX_FIRST) begin
			ch = letters[15:8];
		end else if (idx == IDX_SECOND) begin
			ch = letters[7:0];
		end else if (idx == IDX_SPACE) begin
			ch = CH_SPACE;
		end else if (idx == IDX_SIGN) begin
			ch = neg ? CH_MINUS : CH_PLUS;
		end else if (idx <= IDX_MANT_HI) begin
			// four digits after a leading point
			if (dumpMode && isInputAB) begin
				if (pos == 5'h00) begin
					ch = CH_POINT;
				end else if (pos <= {1'b0, DUMP_AB_DIGITS}) begin
					ch = digitChar(digits, pos - 5'h01);
				end else begin
					ch = CH_ZERO;
				end
			end else if (pos == {1'b0, point}) begin
				ch = CH_POINT;
			// digits below 10 kHz read as zero
			end else if (dumpMode && funcCode == FN_INPUT_C && dig + DUMP_C_ZEROS >= {1'b0, point}) begin
				ch = CH_ZERO;
			end else begin
				ch = digitChar(digits, dig);
			end
		end else if (idx == IDX_E) begin
			ch = CH_E;
		end else if (idx == IDX_EXP_SIGN) begin
			ch = expNeg ? CH_MINUS : CH_PLUS;
		end else if (idx == IDX_EXP_HI) begin
			ch = CH_ZERO | {4'h0, expBcd[7:4]};
		end else begin
			ch = CH_ZERO | {4'h0, expBcd[3:0]};
		end
	end

endmodule

/* File: verilog/result_message_formatter.sv */
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

module result_message_formatter import rmf_pkg::*; #(
	parameter int CYCLES_PER_MS = MS_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// axi4-lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// front panel
	input wire logic resumeKey,
	// measurement engine
	output logic gateActive,
	output logic cycleEnd,
	input wire logic [3:0] resFunc,
	input wire logic resNeg,
	input wire logic [47:0] resDigits,
	input wire logic [3:0] resPoint,
	input wire logic resExpNeg,
	input wire logic [7:0] resExpBcd,
	// instrument bus addressing and commands
	input wire logic listenAddressed,
	input wire logic talkAddressed,
	input wire logic cmdValid,
	input wire logic [1:0] cmdSel,
	input wire logic [15:0] cmdData,
	// message character stream toward the listener
	input wire logic xferReq,
	output logic txValid,
	input wire logic txReady,
	output logic [7:0] txData,
	output logic bufferFull
);

	// ==================================================
	// state
	typedef struct packed {
		logic awDone;
		logic [7:0] awAddr;
		logic wDone;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic holdMode;
		logic dumpMode;
		logic prefixOff;
		logic addressed;
		logic [RES_W-1:0] resolution;
		logic [15:0] sampleSec;
		rmf_meas_type meas;
		logic [31:0] prescale;
		logic [25:0] msLeft;
		logic cycleEnd;
		rmf_result_type buffer;
		rmf_result_type pend;
		logic full;
		logic pendValid;
		rmf_xfer_type xfer;
		logic [4:0] idx;
		logic [7:0] txData;
	} rmf_state_type;

	rmf_state_type q;
	rmf_state_type d;

	// ==================================================
	// helpers
	function automatic logic [25:0] gateMs(input logic [RES_W-1:0] res);
		unique case (res)
			2'h0: gateMs = GATE_MS_RES0;
			2'h1: gateMs = GATE_MS_RES1;
			2'h2: gateMs = GATE_MS_RES2;
			2'h3: gateMs = GATE_MS_RES3;
		endcase
	endfunction

	// shared by the bus slave and the instrument bus command port
	function automatic rmf_state_type regWrite(input rmf_state_type s, input logic [1:0] sel,
			input logic [15:0] data, input logic [1:0] strb);
		regWrite = s;
		if (sel == SEL_CTRL && strb[0]) begin
			regWrite.holdMode = data[CTRL_HOLD];
			regWrite.dumpMode = data[CTRL_DUMP];
			regWrite.prefixOff = data[CTRL_PREFIX_OFF];
			regWrite.addressed = data[CTRL_ADDRESSED];
			regWrite.resolution = data[CTRL_RES_LO +: RES_W];
		end
		if (sel == SEL_SAMPLE) begin
			if (strb[0]) begin
				regWrite.sampleSec[7:0] = data[7:0];
			end
			if (strb[1]) begin
				regWrite.sampleSec[15:8] = data[15:8];
			end
		end
	endfunction

	function automatic logic addrMapped(input logic [7:0] addr);
		addrMapped = addr[7:4] == 4'h0 && addr[1:0] == 2'h0;
	endfunction

	// ==================================================
	// character source and handshakes
	logic [4:0] startIdx;
	logic [4:0] selIdx;
	logic [7:0] selChar;
	logic msTick;
	logic resumeHit;
	logic trigger;
	rmf_result_type incoming;

	// prefix suppression skips the first three bytes
	assign startIdx = q.prefixOff ? IDX_SIGN : IDX_FIRST;
	assign selIdx = (q.xfer == X_SEND) ? q.idx + 5'h01 : startIdx;
	assign msTick = q.prescale == 32'(CYCLES_PER_MS - 1);
	assign incoming = '{resFunc, resNeg, resDigits, resPoint, resExpNeg, resExpBcd};
	// commands only while addressed to listen
	assign resumeHit = resumeKey || (q.awDone && q.wDone && !q.bValid && q.awAddr == ADDR_RESUME)
		|| (cmdValid && q.addressed && listenAddressed && cmdSel == SEL_RESUME);
	assign trigger = xferReq && (!q.addressed || talkAddressed);

	rmf_char_gen charGen (
		.idx(selIdx),
		.funcCode(q.buffer.func),
		.neg(q.buffer.neg),
		.digits(q.buffer.digits),
		.point(q.buffer.point),
		.expNeg(q.buffer.expNeg),
		.expBcd(q.buffer.expBcd),
		.dumpMode(q.dumpMode),
		.ch(selChar)
	);

	assign awready = !q.awDone && !q.bValid;
	assign wready = !q.wDone && !q.bValid;
	assign bvalid = q.bValid;
	assign bresp = q.bResp;
	assign arready = !q.rValid;
	assign rvalid = q.rValid;
	assign rdata = q.rData;
	assign rresp = q.rResp;
	assign gateActive = q.meas == M_GATE;
	assign cycleEnd = q.cycleEnd;
	assign txValid = q.xfer == X_SEND;
	assign txData = q.txData;
	assign bufferFull = q.full;

	// ==================================================
	// next state
	always_comb begin
		d = q;
		d.cycleEnd = 1'b0;

		// bus write: address and data in either order
		if (awvalid && awready) begin
			d.awDone = 1'b1;
			d.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			d.wDone = 1'b1;
			d.wData = wdata;
			d.wStrb = wstrb;
		end
		if (cmdValid && q.addressed && listenAddressed) begin
			d = regWrite(d, cmdSel, cmdData, 2'h3);
		end
		if (q.awDone && q.wDone && !q.bValid) begin
			d.awDone = 1'b0;
			d.wDone = 1'b0;
			d.bValid = 1'b1;
			// status is read only, unmapped words answer with an error
			if (addrMapped(q.awAddr) && q.awAddr[3:2] != SEL_STATUS) begin
				d.bResp = RESP_OKAY;
				d = regWrite(d, q.awAddr[3:2], q.wData[15:0], q.wStrb[1:0]);
			end else begin
				d.bResp = RESP_SLVERR;
			end
		end
		if (q.bValid && bready) begin
			d.bValid = 1'b0;
		end

		// bus read
		if (arvalid && arready) begin
			d.rValid = 1'b1;
			d.rData = 32'h0000_0000;
			d.rResp = RESP_OKAY;
			unique case (araddr)
				ADDR_CTRL: begin
					d.rData[CTRL_HOLD] = q.holdMode;
					d.rData[CTRL_DUMP] = q.dumpMode;
					d.rData[CTRL_PREFIX_OFF] = q.prefixOff;
					d.rData[CTRL_ADDRESSED] = q.addressed;
					d.rData[CTRL_RES_LO +: RES_W] = q.resolution;
				end
				ADDR_SAMPLE: d.rData[15:0] = q.sampleSec;
				ADDR_RESUME: d.rData = 32'h0000_0000;
				ADDR_STATUS: begin
					d.rData[STAT_FULL] = q.full;
					d.rData[STAT_PEND] = q.pendValid;
					d.rData[STAT_WAIT] = q.xfer == X_WAIT;
					d.rData[STAT_SEND] = q.xfer == X_SEND;
					d.rData[STAT_GATE] = q.meas == M_GATE;
					d.rData[STAT_DWELL] = q.meas == M_DWELL;
				end
				default: d.rResp = RESP_SLVERR;
			endcase
		end else if (q.rValid && rready) begin
			d.rValid = 1'b0;
		end

		// transfer sequencing, evaluated before the buffer load below
		unique case (q.xfer)
			X_IDLE: begin
				if (trigger) begin
					if (q.full) begin
						d.xfer = X_SEND;
						d.idx = startIdx;
						d.txData = selChar;
					end else begin
						d.xfer = X_WAIT;
					end
				end
			end
			X_WAIT: begin
				// send the newest result once loaded
				if (q.full) begin
					d.xfer = X_SEND;
					d.idx = startIdx;
					d.txData = selChar;
				end
			end
			X_SEND: begin
				if (txReady) begin
					if (q.idx == MSG_LEN) begin
						d.xfer = X_IDLE;
						d.full = 1'b0;
						// deferred result now takes the buffer
						if (q.pendValid) begin
							d.buffer = q.pend;
							d.full = 1'b1;
							d.pendValid = 1'b0;
						end
					end else begin
						d.idx = selIdx;
						d.txData = selChar;
					end
				end
			end
			default: d.xfer = X_IDLE;
		endcase

		// measurement cycle timing, ms prescaler restarts at each phase
		d.prescale = msTick ? 32'h0000_0000 : q.prescale + 32'h0000_0001;
		unique case (q.meas)
			M_IDLE: begin
				// hold mode waits for a resume from the key, the bus resume word or a listener command
				if (!q.holdMode || resumeHit) begin
					d.meas = M_GATE;
					d.msLeft = gateMs(q.resolution);
					d.prescale = 32'h0000_0000;
				end
			end
			M_GATE: begin
				if (msTick) begin
					d.msLeft = q.msLeft - 26'h0000001;
					if (q.msLeft <= 26'h0000001) begin
						d.cycleEnd = 1'b1;
						// defer the update while a message is leaving
						if (d.xfer == X_SEND) begin
							d.pend = incoming;
							d.pendValid = 1'b1;
						end else begin
							d.buffer = incoming;
							d.full = 1'b1;
						end
						// dwell for the sample store seconds
						if (q.sampleSec == 16'h0000) begin
							d.meas = M_IDLE;
						end else begin
							d.meas = M_DWELL;
							d.msLeft = 26'(q.sampleSec * MS_PER_S);
						end
					end
				end
			end
			M_DWELL: begin
				if (msTick) begin
					d.msLeft = q.msLeft - 26'h0000001;
					if (q.msLeft <= 26'h0000001) begin
						d.meas = M_IDLE;
					end
				end
			end
			default: d.meas = M_IDLE;
		endcase
	end

	// ==================================================
	// state register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.sampleSec <= SAMPLE_RESET;
			q.meas <= M_IDLE;
			q.xfer <= X_IDLE;
		end else begin
			q <= d;
		end
	end

endmodule

/* File: sim/rmf_checker.sv */
`timescale 1ns/1ps

// ========================================
// port checks for the message formatter
module rmf_checker import rmf_pkg::*; #(
	parameter int CYCLES_PER_MS = MS_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// register bus answers
	input wire logic arready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// measurement
	input wire logic gateActive,
	input wire logic cycleEnd,
	// character stream
	input wire logic xferReq,
	input wire logic talkAddressed,
	input wire logic txValid,
	input wire logic txReady,
	input wire logic [7:0] txData,
	input wire logic bufferFull
);
	localparam int G0 = int'(GATE_MS_RES0) * CYCLES_PER_MS;
	localparam int G1 = int'(GATE_MS_RES1) * CYCLES_PER_MS;
	localparam int G2 = int'(GATE_MS_RES2) * CYCLES_PER_MS;
	localparam int G3 = int'(GATE_MS_RES3) * CYCLES_PER_MS;
	logic [31:0] gateRun_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	// high cycles of the running gate, cleared when it drops
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			gateRun_q <= 32'h0;
		else
			gateRun_q <= gateActive ? gateRun_q + 32'h1 : 32'h0;
	end

	a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
		else $error("character changed before it was taken");
	a_send_full: assert property (txValid |-> bufferFull)
		else $error("sending from an empty buffer");
	a_start_send: assert property (xferReq && talkAddressed && bufferFull && !txValid |=> txValid)
		else $error("trigger on a full buffer did not start sending");
	a_end_pulse: assert property (cycleEnd |=> !cycleEnd)
		else $error("cycle end longer than one cycle");
	a_end_follows: assert property ($fell(gateActive) |-> ##[0:1] cycleEnd)
		else $error("gate closed without a cycle end");
	a_load_on_end: assert property (cycleEnd |-> ##[0:1] bufferFull)
		else $error("cycle end did not load the buffer");
	a_gate_len: assert property ($fell(gateActive) |-> (gateRun_q == G0 || gateRun_q == G1 || gateRun_q == G2 || gateRun_q == G3))
		else $error("gate length off the resolution table");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_ar_block: assert property (rvalid |-> !arready)
		else $error("read address taken while a read is open");
endmodule

bind result_message_formatter rmf_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk_u (
	.clock(clock), .arst_n(arst_n), .arready(arready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
	.rvalid(rvalid), .rready(rready), .rdata(rdata), .gateActive(gateActive), .cycleEnd(cycleEnd),
	.xferReq(xferReq), .talkAddressed(talkAddressed), .txValid(txValid), .txReady(txReady),
	.txData(txData), .bufferFull(bufferFull)
);

/* File: sim/rmf_listener.sv */
`timescale 1ns/1ps

// ========================================
// listener on the character stream
module rmf_listener (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// trigger pulse from the bench
	input wire logic go,
	// stream
	output logic xferReq,
	input wire logic txValid,
	output logic txReady,
	input wire logic [7:0] txData
);
	logic [7:0] rx[$];

	// unit left to receiver
	// random stalls so the sender must hold each character
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			xferReq <= 1'h0;
			txReady <= 1'h0;
		end else begin
			xferReq <= go;
			txReady <= ($urandom % 4) != 0;
			if (txValid && txReady)
				rx.push_back(txData);
		end
	end
endmodule

/* File: sim/result_message_formatter_tb_top.sv */
`timescale 1ns/1ps

// ========================================
// bench: hold mode gives exact control of each cycle
module result_message_formatter_tb_top import rmf_pkg::*;;
	localparam int CPM = 4;
	localparam int LIM = 5000;
	logic clock, arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr, txData;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rsp, cmdSel;
	logic [3:0] resFunc, resPoint;
	logic [47:0] resDigits;
	logic [7:0] resExpBcd, exp[$], keep[$];
	logic [15:0] cmdData;
	logic resumeKey, gateActive, cycleEnd, resNeg, resExpNeg, listenAddressed, talkAddressed, cmdValid;
	logic xferReq, txValid, txReady, bufferFull, go, dm, po;
	int bad_count, checks, n, i, j, k;
	time t0;

	result_message_formatter #(.CYCLES_PER_MS(CPM)) dut_u (.clock(clock), .arst_n(arst_n),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .resumeKey(resumeKey), .gateActive(gateActive),
		.cycleEnd(cycleEnd), .resFunc(resFunc), .resNeg(resNeg), .resDigits(resDigits),
		.resPoint(resPoint), .resExpNeg(resExpNeg), .resExpBcd(resExpBcd),
		.listenAddressed(listenAddressed), .talkAddressed(talkAddressed), .cmdValid(cmdValid),
		.cmdSel(cmdSel), .cmdData(cmdData), .xferReq(xferReq), .txValid(txValid), .txReady(txReady),
		.txData(txData), .bufferFull(bufferFull));
	rmf_listener lst_u (.clock(clock), .arst_n(arst_n), .go(go), .xferReq(xferReq), .txValid(txValid),
		.txReady(txReady), .txData(txData));

	// clock, 4 ns period
	initial begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end

	// ========================================
	// checking and closing
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic tmo(input int c);
		if (c >= LIM) begin
			bad_count++;
			$display("mismatch wait bound expected %0d seen %0d", LIM, c);
			test_done();
		end
	endtask

	// ========================================
	// register bus master, one transfer at a time
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int c;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (c = 0; c < LIM; c++) begin
			@(posedge clock);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		rsp = bresp;
		bready <= 1'h0;
		tmo(c);
	endtask
	task automatic rdr(input logic [7:0] a);
		int c;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (c = 0; c < LIM; c++) begin
			@(posedge clock);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		rd = rdata;
		rsp = rresp;
		rready <= 1'h0;
		tmo(c);
	endtask

	// ========================================
	// message model
	task automatic build;
		string lt;
		int x;
		logic ab, cz;
		lt = "FAFBFCCKCBCABARSMNOSMUSAHNLO";
		ab = dm && resFunc <= FN_INPUT_B;
		cz = dm && resFunc == FN_INPUT_C;
		exp = {};
		if (!po) begin
			exp.push_back(lt[2 * resFunc]);
			exp.push_back(lt[2 * resFunc + 1]);
			exp.push_back(CH_SPACE);
		end
		exp.push_back(resNeg ? CH_MINUS : CH_PLUS);
		for (x = 0; x < 12; x++) begin
			if (x == (ab ? 0 : resPoint)) exp.push_back(CH_POINT);
			exp.push_back((ab ? x >= 4 : cz && x + 4 >= resPoint) ? CH_ZERO : CH_ZERO | 8'(resDigits[47 - 4 * x -: 4]));
		end
		if (!ab && resPoint == 12) exp.push_back(CH_POINT);
		exp.push_back(CH_E);
		exp.push_back(resExpNeg ? CH_MINUS : CH_PLUS);
		exp.push_back(CH_ZERO | 8'(resExpBcd[7:4]));
		exp.push_back(CH_ZERO | 8'(resExpBcd[3:0]));
	endtask
	// new random result, exponent a multiple of three
	task automatic rnd(input int f);
		int x, e;
		logic [47:0] d;
		for (x = 0; x < 12; x++) d[4 * x +: 4] = 4'($urandom % 10);
		e = ($urandom % 6) * 3;
		@(posedge clock);
		resFunc <= 4'(f);
		resNeg <= 1'($urandom);
		resDigits <= d;
		resPoint <= 4'($urandom % 13);
		resExpNeg <= 1'($urandom);
		resExpBcd <= {4'(e / 10), 4'(e % 10)};
		@(posedge clock);
		build();
	endtask
	task automatic press(input logic viaBus);
		repeat (4) @(posedge clock);
		if (viaBus) begin
			wr(ADDR_RESUME, 32'h1);
		end else begin
			resumeKey <= 1'h1;
			@(posedge clock);
			resumeKey <= 1'h0;
		end
	endtask
	task automatic wait_end;
		int c;
		for (c = 0; c < LIM; c++) begin
			@(posedge clock);
			if (cycleEnd) break;
		end
		tmo(c);
	endtask
	task automatic trig;
		@(posedge clock);
		go <= 1'h1;
		@(posedge clock);
		go <= 1'h0;
	endtask
	task automatic cmd;
		@(posedge clock);
		cmdValid <= 1'h1;
		@(posedge clock);
		cmdValid <= 1'h0;
	endtask
	// outputs that move during a quiet window
	task automatic quiet;
		n = 0;
		repeat (40) begin
			@(posedge clock);
			if (txValid !== 1'h0 || cycleEnd !== 1'h0) n++;
		end
	endtask
	task automatic get_msg(input logic full);
		int c;
		for (c = 0; c < LIM && lst_u.rx.size() < exp.size(); c++) @(posedge clock);
		tmo(c);
		for (c = 0; c < LIM && txValid !== 1'h0; c++) @(posedge clock);
		tmo(c);
		chk("buffer full after message", full, bufferFull);
		chk("message length", exp.size(), lst_u.rx.size());
		for (c = 0; c < exp.size(); c++) chk("message character", exp[c], lst_u.rx[c]);
		lst_u.rx = {};
	endtask

	// ========================================
	// main sequence
	initial begin
		void'($urandom(32'he78273fa));
		{arst_n, awvalid, wvalid, bready, arvalid, rready, resumeKey, cmdValid, go, listenAddressed} = 10'h0;
		{awaddr, araddr, wdata, resFunc, resPoint, resDigits, resExpBcd, resNeg, resExpNeg} = '0;
		talkAddressed = 1'h1;
		cmdSel = SEL_RESUME;
		cmdData = 16'h1;
		dm = 1'h0;
		po = 1'h0;
		repeat (2) @(posedge clock);
		arst_n <= 1'h1;
		@(posedge clock);
		chk("buffer after reset", 0, bufferFull);
		rdr(ADDR_CTRL);
		chk("control reset", 0, rd);
		rdr(8'h10);
		chk("unmapped read", RESP_SLVERR, rsp);
		wr(ADDR_STATUS, 32'h1);
		chk("status write", RESP_SLVERR, rsp);
		wr(ADDR_CTRL, 32'h1);
		repeat (40) @(posedge clock);
		quiet();
		chk("cycles without resume", 0, n);
		// every code and mode; newest load wins, or an early trigger waits
		for (k = 0; k < 18; k++) begin
			dm = k[1];
			po = k[0];
			wr(ADDR_CTRL, {29'h0, po, dm, 1'h1});
			if (k[2]) trig();
			for (j = 0; j < (k[2] ? 1 : 2); j++) begin
				rnd(k < 14 ? k : k - 14);
				press(k[3]);
				wait_end();
			end
			if (!k[2]) trig();
			get_msg(1'h0);
		end
		// cycle end during a transfer is deferred
		dm = 1'h0;
		po = 1'h0;
		wr(ADDR_CTRL, 32'h1);
		rnd(FN_INPUT_C);
		press(1'h0);
		wait_end();
		trig();
		for (i = 0; i < LIM && lst_u.rx.size() < 2; i++) @(posedge clock);
		tmo(i);
		keep = exp;
		rnd(FN_INPUT_A);
		press(1'h0);
		wait_end();
		exp = keep;
		get_msg(1'h1);
		// the deferred result still stands on the engine pins, so rebuild rather than draw anew
		build();
		trig();
		get_msg(1'h0);
		// resolution one gate
		wr(ADDR_CTRL, 32'h11);
		press(1'h0);
		for (i = 0; i < LIM && gateActive !== 1'h1; i++) @(posedge clock);
		tmo(i);
		for (n = 0; n < LIM && gateActive === 1'h1; n++) @(posedge clock);
		chk("gate cycles", int'(GATE_MS_RES1) * CPM, n);
		// dwell of one second from the sample store, free running
		wr(ADDR_SAMPLE, 32'h1);
		wr(ADDR_CTRL, 32'h0);
		for (i = 0; i < LIM && gateActive !== 1'h1; i++) @(posedge clock);
		tmo(i);
		for (i = 0; i < LIM && gateActive === 1'h1; i++) @(posedge clock);
		tmo(i);
		t0 = $time;
		// dwell length is latched at the gate end, so clearing the store now only stops the next dwell
		wr(ADDR_SAMPLE, 32'h0);
		for (i = 0; i < LIM && gateActive !== 1'h1; i++) @(posedge clock);
		tmo(i);
		// one idle cycle launches the next gate
		chk("dwell cycles", int'(MS_PER_S) * CPM + 1, int'(($time - t0) / CLOCK_PERIOD_NS));
		// addressed: no commands unless listener, no output unless talker
		wr(ADDR_CTRL, 32'h9);
		talkAddressed <= 1'h0;
		trig();
		cmd();
		quiet();
		chk("activity while not addressed", 0, n);
		listenAddressed <= 1'h1;
		rnd(FN_LOCAL_OSC);
		cmd();
		wait_end();
		talkAddressed <= 1'h1;
		trig();
		get_msg(1'h0);
		test_done();
	end
endmodule
